// ---- amg_guard.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Check every read, write and fetch.
// R2: Decide only from protect state and area.
// R3: Protected: RAM open except stack, working.
// R4: Protected: shared RAM closed unless enabled.
// R5: Protected: non-RAM closed except application area.
// R6: Protected: call relief area stays open.
// R7: Protected: return relief area stays open.
// R8: Protected: registers open except system register.
// R9: Unprotected: everything allowed.
// R10: Only unprotected software makes rules effective.
// R11: Written rules pend until unprotected acceptance.
// R12: Reset gives permissive attributes.
// R13: Unprotected software may load other initials.
// R14: Only unprotected software switches protection on.
// R15: Off only via call/return relief or interrupt.
// R16: Refusal blocks write, masks read, flags violation.
module amg_guard (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic i_fetch,
	input wire logic [amg_pkg::AMG_AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_mem_rdata,
	input wire logic i_prot_on_req,
	input wire logic i_privileged_call_instr,
	input wire logic i_privileged_return_instr,
	input wire logic i_irq_taken,
	input wire logic i_prop_wr,
	input wire logic i_prop_csr_en,
	input wire logic [amg_pkg::AMG_AW-1:0] i_prop_app_lo,
	input wire logic [amg_pkg::AMG_AW-1:0] i_prop_app_hi,
	input wire logic i_accept,
	input wire logic i_init_wr,
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [amg_pkg::AMG_AW-1:0] o_mem_addr,
	output logic [7:0] o_mem_wdata,
	output logic [7:0] o_rdata,
	output logic o_violation,
	output logic o_prot
);
	import amg_pkg::*;

	amg_chk_if chk ();

	// Protect state
	amg_state_t st_q, st_d;
	logic prot;
	logic may_manage;
	logic go_on;
	logic go_off;

	// Attributes in force and the pending proposal
	logic csr_en_q, csr_en_d;
	logic [15:0] app_lo_q, app_lo_d, app_hi_q, app_hi_d;
	logic p_csr_en_q, p_csr_en_d;
	logic [15:0] p_lo_q, p_lo_d, p_hi_q, p_hi_d;

	// Response to the core
	logic [7:0] rdata_q, rdata_d;
	logic viol_q, viol_d;

	// Relief decode
	logic call_hit;
	logic ret_hit;
	logic cross_ok;

	// Address inside an inclusive fixed area
	function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_area = (a >= lo) && (a <= hi);
	endfunction : in_area

	// Protection level; every management action needs it off
	assign prot = (st_q == AMG_ST_ON);
	assign may_manage = !prot; // R10 R13 R14

	// Attributes in force feed the area checker
	always_comb begin
		chk.attr.prot = prot;
		chk.attr.csr_en = csr_en_q;
		chk.attr.app_lo = app_lo_q;
		chk.attr.app_hi = app_hi_q;
		chk.addr = i_addr;
	end

	amg_area_check u_check (
		.bus(chk.chk)
	);

	// Relief fetch must land in the area of its own instruction; any
	// other open address would let protected code switch protection off
	assign call_hit = i_privileged_call_instr && in_area(i_addr, AMG_CALL_LO, AMG_CALL_HI); // R15
	assign ret_hit = i_privileged_return_instr && in_area(i_addr, AMG_RET_LO, AMG_RET_HI); // R15
	assign cross_ok = i_fetch && (call_hit || ret_hit); // R15

	// Switch requests, each honoured only in the state it leaves
	assign go_on = may_manage && i_prot_on_req; // R14
	assign go_off = i_irq_taken || cross_ok; // R15

	// Protect state next value
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			AMG_ST_OFF: begin
				if (go_on) begin
					st_d = AMG_ST_ON; // R14
				end
			end
			AMG_ST_ON: begin
				if (go_off) begin
					st_d = AMG_ST_OFF; // R15
				end
			end
			default: st_d = AMG_ST_OFF;
		endcase
	end

	// Proposal next value: any software may write it, it stays inert
	always_comb begin
		p_csr_en_d = p_csr_en_q;
		p_lo_d = p_lo_q;
		p_hi_d = p_hi_q;
		if (i_prop_wr) begin
			p_csr_en_d = i_prop_csr_en; // R11
			p_lo_d = i_prop_app_lo;
			p_hi_d = i_prop_app_hi;
		end
	end

	// Attributes in force next value; a direct load wins over acceptance
	// so one initial write is never replaced by a stale proposal
	always_comb begin
		csr_en_d = csr_en_q;
		app_lo_d = app_lo_q;
		app_hi_d = app_hi_q;
		if (may_manage && i_init_wr) begin
			csr_en_d = i_prop_csr_en; // R13
			app_lo_d = i_prop_app_lo;
			app_hi_d = i_prop_app_hi;
		end else if (may_manage && i_accept) begin
			csr_en_d = p_csr_en_q; // R10 R11
			app_lo_d = p_lo_q;
			app_hi_d = p_hi_q;
		end
	end

	// Read data and violation next values; a refused read returns
	// zero so nothing from a closed area reaches the core
	always_comb begin
		rdata_d = '0;
		viol_d = 1'b0;
		if (i_req) begin
			if (chk.allow) begin // R1
				rdata_d = i_mem_rdata;
			end else begin
				viol_d = 1'b1; // R16
			end
		end
	end

	// Protect state register, off at reset
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= AMG_ST_OFF; // R12
		end else begin
			st_q <= st_d;
		end
	end

	// Proposal register
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			p_csr_en_q <= AMG_CSR_EN_RST;
			p_lo_q <= AMG_APP_LO_RST;
			p_hi_q <= AMG_APP_HI_RST;
		end else begin
			p_csr_en_q <= p_csr_en_d;
			p_lo_q <= p_lo_d;
			p_hi_q <= p_hi_d;
		end
	end

	// Attributes in force, permissive defaults at reset
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			csr_en_q <= AMG_CSR_EN_RST; // R12
			app_lo_q <= AMG_APP_LO_RST;
			app_hi_q <= AMG_APP_HI_RST;
		end else begin
			csr_en_q <= csr_en_d;
			app_lo_q <= app_lo_d;
			app_hi_q <= app_hi_d;
		end
	end

	// Response registers, one-cycle answer to each request
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= '0;
			viol_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			viol_q <= viol_d;
		end
	end

	// Memory side: refused requests never reach memory
	assign o_mem_req = i_req && chk.allow; // R16
	assign o_mem_we = i_req && i_we && chk.allow; // R16
	assign o_mem_addr = i_addr;
	assign o_mem_wdata = i_wdata;

	// Core side
	assign o_rdata = rdata_q;
	assign o_violation = viol_q;
	assign o_prot = prot;
endmodule : amg_guard
`default_nettype wire

// ---- amg_pkg.sv ----
package amg_pkg;
	// Address width of the core's access bus
	localparam int AMG_AW = 16;

	// Area map: base and last address of each area (plain defaults)
	localparam logic [15:0] AMG_RAM_LO = 16'h0000;
	localparam logic [15:0] AMG_RAM_HI = 16'h0FFF;
	localparam logic [15:0] AMG_STK_LO = 16'h0F00;
	localparam logic [15:0] AMG_STK_HI = 16'h0FFF;
	localparam logic [15:0] AMG_WRK_LO = 16'h0E00;
	localparam logic [15:0] AMG_WRK_HI = 16'h0EFF;
	localparam logic [15:0] AMG_CSR_LO = 16'h1000;
	localparam logic [15:0] AMG_CSR_HI = 16'h13FF;
	localparam logic [15:0] AMG_GPR_LO = 16'hFF00;
	localparam logic [15:0] AMG_GPR_HI = 16'hFF0F;
	localparam logic [15:0] AMG_SYS_ADR = 16'hFF0F;
	localparam logic [15:0] AMG_CALL_LO = 16'h2000;
	localparam logic [15:0] AMG_CALL_HI = 16'h20FF;
	localparam logic [15:0] AMG_RET_LO = 16'h2100;
	localparam logic [15:0] AMG_RET_HI = 16'h21FF;
	localparam logic [15:0] AMG_APP_LO_RST = 16'h4000;
	localparam logic [15:0] AMG_APP_HI_RST = 16'h7FFF;

	// Attribute reset values: protection off, shared RAM closed
	localparam logic AMG_PROT_RST = 1'b0;
	localparam logic AMG_CSR_EN_RST = 1'b0;

	// Bundle of attributes in force
	typedef struct packed {
		logic prot;
		logic csr_en;
		logic [15:0] app_lo;
		logic [15:0] app_hi;
	} amg_attr_t;

	// Protect state machine
	typedef enum logic [1:0] {
		AMG_ST_OFF = 2'b01,
		AMG_ST_ON = 2'b10
	} amg_state_t;
endpackage : amg_pkg

// ---- amg_chk_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Attributes in force and the access to judge, shared by top and checker
interface amg_chk_if;
	import amg_pkg::*;
	amg_attr_t attr;
	logic [AMG_AW-1:0] addr;
	logic allow;
	modport ctl (output attr, output addr, input allow);
	modport chk (input attr, input addr, output allow);
endinterface : amg_chk_if
`default_nettype wire

// ---- amg_area_check.sv ----
`timescale 1ns/1ps
`default_nettype none
module amg_area_check (
	amg_chk_if.chk bus
);
	import amg_pkg::*;

	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	logic ram_ok;
	logic oth_ok;

	// RAM open except stack and working area; shared RAM open only when enabled
	always_comb begin
		ram_ok = in_rng(bus.addr, AMG_RAM_LO, AMG_RAM_HI)
			&& !in_rng(bus.addr, AMG_STK_LO, AMG_STK_HI) // R3
			&& !in_rng(bus.addr, AMG_WRK_LO, AMG_WRK_HI); // R3
		oth_ok = (in_rng(bus.addr, AMG_CSR_LO, AMG_CSR_HI) && bus.attr.csr_en) // R4
			|| in_rng(bus.addr, bus.attr.app_lo, bus.attr.app_hi) // R5
			|| in_rng(bus.addr, AMG_CALL_LO, AMG_CALL_HI) // R6
			|| in_rng(bus.addr, AMG_RET_LO, AMG_RET_HI) // R7
			|| (in_rng(bus.addr, AMG_GPR_LO, AMG_GPR_HI) && bus.addr != AMG_SYS_ADR); // R8
	end

	// Decision uses only protect state and area
	assign bus.allow = !bus.attr.prot || ram_ok || oth_ok; // R2 R9
endmodule : amg_area_check
`default_nettype wire

// ---- amg_guard_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port checks on the guard
module amg_guard_chk (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic i_fetch,
	input wire logic [15:0] i_addr,
	input wire logic i_prot_on_req,
	input wire logic i_privileged_call_instr,
	input wire logic i_privileged_return_instr,
	input wire logic i_irq_taken,
	input wire logic o_mem_req,
	input wire logic o_mem_we,
	input wire logic [7:0] o_rdata,
	input wire logic o_violation,
	input wire logic o_prot
);
	import amg_pkg::*;
	// Fetch into the relief area matching its instruction
	wire logic call_ok = i_fetch && i_privileged_call_instr && (i_addr inside {[AMG_CALL_LO:AMG_CALL_HI]});
	wire logic ret_ok = i_fetch && i_privileged_return_instr && (i_addr inside {[AMG_RET_LO:AMG_RET_HI]});
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	AST_OPEN: assert property (!o_prot && i_req |-> o_mem_req) else $error("refused while open");
	AST_STK: assert property (o_prot && i_req && i_addr inside {[16'h0E00:16'h0FFF]} |-> !o_mem_req) else $error("stk");
	AST_REL: assert property (o_prot && i_req && i_addr inside {[16'h2000:16'h21FF]} |-> o_mem_req) else $error("rel");
	AST_SYS: assert property (o_prot && i_req && i_addr == 16'hFF0F |-> !o_mem_req) else $error("sys");
	AST_VIO: assert property (1'b1 |=> o_violation == $past(i_req && !o_mem_req)) else $error("vio");
	AST_MASK: assert property (i_req && !o_mem_req |=> o_rdata == 8'h00) else $error("mask");
	AST_WE: assert property (o_mem_we |-> o_mem_req && i_we) else $error("we");
	AST_ON: assert property ($rose(o_prot) |-> $past(i_prot_on_req)) else $error("on");
	AST_OFF: assert property ($fell(o_prot) |-> $past(i_irq_taken || call_ok || ret_ok)) else $error("off");
	cover property (o_violation);
	cover property ($rose(o_prot));
	cover property ($fell(o_prot));
	cover property (o_prot && o_mem_we);
endmodule : amg_guard_chk
bind amg_guard amg_guard_chk u_guard_chk (.*);
`default_nettype wire

// ---- amg_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Memory behind the guard, read in the same cycle
module amg_mem_model (
	input wire logic [15:0] i_addr,
	output logic [7:0] o_data
);
	assign o_data = i_addr[7:0] ^ i_addr[15:8];
endmodule : amg_mem_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import amg_pkg::*;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_req = 1'b0, i_we = 1'b0, i_fetch = 1'b0, i_prop_csr_en = 1'b0;
	logic i_privileged_call_instr = 1'b0, i_privileged_return_instr = 1'b0;
	logic [4:0] p = 5'h00;
	logic [15:0] i_addr = 16'h0000, i_prop_app_lo = 16'h0000, i_prop_app_hi = 16'h0000;
	logic [7:0] i_wdata = 8'h5A, i_mem_rdata, o_mem_wdata, o_rdata;
	logic o_mem_req, o_mem_we, o_violation, o_prot;
	logic [15:0] o_mem_addr;
	wire logic i_prot_on_req = p[0];
	wire logic i_irq_taken = p[1];
	wire logic i_prop_wr = p[2];
	wire logic i_accept = p[3];
	wire logic i_init_wr = p[4];
	int err_total = 0, n_checks = 0;
	amg_guard uut (.*);
	amg_mem_model mem (.i_addr(o_mem_addr), .o_data(i_mem_rdata));
	always #5 i_mclk = ~i_mclk;
	task automatic chk(input string n, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	// One-edge pulse on a control
	task automatic pls(input int k);
		@(posedge i_mclk) p[k] <= 1'b1;
		@(posedge i_mclk) p[k] <= 1'b0;
		#1 ;
	endtask : pls
	// One access, expected allowed or refused
	task automatic acc(input logic [15:0] a, input logic e, input logic w = 1'b0);
		@(posedge i_mclk);
		i_req <= 1'b1;
		i_addr <= a;
		i_we <= w;
		#1 chk("req", {o_mem_req, o_mem_we}, {e, e & w});
		chk("addr", o_mem_addr, a);
		chk("wdata", o_mem_wdata, i_wdata);
		@(posedge i_mclk);
		i_req <= 1'b0;
		i_we <= 1'b0;
		#1 chk("vio", {o_violation, w ? 8'h00 : o_rdata}, {!e, e && !w ? a[7:0] ^ a[15:8] : 8'h00});
	endtask : acc
	task automatic t_map();
		logic [15:0] ad [10] = '{16'h0100, 16'h0E00, 16'h0F80, 16'h1000, 16'h4000, 16'h8000, 16'h2000, 16'h2100,
			16'hFF00, 16'hFF0F};
		logic [9:0] ex = 10'b0111010001;
		acc(16'h0F00, 1'b1);
		acc(16'hFF0F, 1'b1, 1'b1);
		pls(0);
		chk("prot", o_prot, 1'b1);
		for (int i = 0; i < 10; i++) acc(ad[i], ex[i]);
		acc(16'h0100, 1'b1, 1'b1);
	endtask : t_map
	task automatic t_prop();
		@(posedge i_mclk);
		i_prop_csr_en <= 1'b1;
		i_prop_app_lo <= 16'h8000;
		i_prop_app_hi <= 16'h8FFF;
		pls(2);
		pls(3);
		acc(16'h1000, 1'b0);
		pls(1);
		chk("prot", o_prot, 1'b0);
		pls(3);
		pls(0);
		acc(16'h8000, 1'b1);
		acc(16'h4000, 1'b0);
		acc(16'h1000, 1'b1);
		pls(1);
		@(posedge i_mclk);
		i_prop_app_lo <= 16'h9000;
		i_prop_app_hi <= 16'h9FFF;
		pls(4);
		pls(0);
		acc(16'h9000, 1'b1);
		acc(16'h8000, 1'b0);
	endtask : t_prop
	task automatic t_rel(input logic r);
		@(posedge i_mclk);
		i_privileged_call_instr <= !r;
		i_privileged_return_instr <= r;
		i_fetch <= 1'b1;
		acc(16'h0100, 1'b1);
		chk("prot", o_prot, 1'b1);
		acc(r ? 16'h2000 : 16'h2100, 1'b1);
		chk("prot", o_prot, 1'b1);
		acc(r ? 16'h2100 : 16'h2000, 1'b1);
		chk("prot", o_prot, 1'b0);
		@(posedge i_mclk);
		{i_privileged_call_instr, i_privileged_return_instr, i_fetch} <= 3'h0;
		pls(0);
	endtask : t_rel
	// Reset in mid-run brings back the permissive attributes
	task automatic t_rst();
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		#1 chk("prot", o_prot, 1'b0);
		acc(16'h0E00, 1'b1);
		pls(0);
		acc(16'h4000, 1'b1);
		acc(16'h9000, 1'b0);
		acc(16'h1000, 1'b0);
	endtask : t_rst
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		repeat (8) @(posedge i_mclk);
		i_rst <= 1'b0;
		#1 chk("prot", o_prot, 1'b0);
		t_map();
		t_prop();
		t_rel(1'b0);
		t_rel(1'b1);
		t_rst();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
